// file: include/bpc_pkg.sv
// package for the primary configuration header block
// assumes an ahb-lite master with 32-bit single word transfers
`default_nettype none
package bpc_pkg;
  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam logic [7:0] BPC_OFF_IDENT = 8'h00;
  localparam logic [7:0] BPC_OFF_CMDSTAT = 8'h04;
  localparam logic [7:0] BPC_OFF_REV = 8'h08;
  localparam logic [7:0] BPC_OFF_EVENT = 8'h40;
  // ----------------------------------------
  // command bit positions
  // ----------------------------------------
  localparam int BPC_CMD_IO = 0;
  localparam int BPC_CMD_MEM = 1;
  localparam int BPC_CMD_MASTER = 2;
  localparam int BPC_CMD_PALETTE = 5;
  localparam int BPC_CMD_PARITY = 6;
  localparam int BPC_CMD_SERR = 8;
  localparam int BPC_CMD_FB2B = 9;
  // writable command bits: 0,1,2,5,6,8,9
  localparam logic [15:0] BPC_CMD_WMASK = 16'h0367;
  // ----------------------------------------
  // status bit positions (within 32-bit word)
  // ----------------------------------------
  localparam int BPC_ST_DPE_MASTER = 24;
  localparam int BPC_ST_SIG_TABORT = 27;
  localparam int BPC_ST_RCV_TABORT = 28;
  localparam int BPC_ST_RCV_MABORT = 29;
  localparam int BPC_ST_SIG_SERR = 30;
  localparam int BPC_ST_PARITY = 31;
  // fixed status: cap list, 66 mhz, fast b2b, medium decode 01
  localparam logic [15:0] BPC_STATUS_FIXED = 16'h02B0;
  localparam int BPC_NUM_FLAGS = 6;
  // ----------------------------------------
  // palette snoop ports (low ten address bits)
  // ----------------------------------------
  localparam logic [9:0] BPC_PAL_A = 10'h3C6;
  localparam logic [9:0] BPC_PAL_B = 10'h3C8;
  localparam logic [9:0] BPC_PAL_C = 10'h3C9;
  // ahb codes
  localparam logic [1:0] BPC_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] BPC_HTRANS_SEQ = 2'h3;

  // sticky events from the bridge core, one-cycle pulses
  typedef struct packed {
    logic parity_any;
    logic serr_assert;
    logic rcv_mabort;
    logic rcv_tabort;
    logic sig_tabort;
    logic dpe_master;
  } bpc_events_t;

  // primary transaction decode request
  typedef struct packed {
    logic is_io;
    logic is_mem;
    logic is_write;
    logic [15:0] addr;
  } bpc_decode_t;

  // enables handed to the datapath
  typedef struct packed {
    logic io_respond;
    logic mem_respond;
    logic master_enable;
    logic palette_snoop;
    logic parity_respond;
    logic fast_b2b_enable;
  } bpc_enables_t;
endpackage : bpc_pkg
`default_nettype wire

// file: rtl/bpc_flag.sv
// one write-one-to-clear sticky status flag
// assumes set and clear are synchronous to hclk
`default_nettype none
module bpc_flag
  import bpc_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic set,
  input wire logic clear,
  output logic flag
);
  logic next_flag;

  // set wins over a clear in the same cycle
  always_comb begin
    next_flag = flag;
    if (clear) begin
      next_flag = 1'b0;
    end
    if (set) begin
      next_flag = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flag <= 1'b0;
    end else if (clk_en) begin
      flag <= next_flag;
    end
  end
endmodule : bpc_flag
`default_nettype wire

// file: rtl/bpc_cfg_header.sv
// primary configuration header: identity, command, primary status
// assumes one ahb-lite master and a bridge core on the same hclk
//
// Functional notes
// - command bit 0 enables I/O response
// - command bit 1 enables memory response
// - bit 2 gates primary mastering, secondary response
// - special cycle bit reads zero
// - invalidate bit reads zero, only forwarded
// - bit 5 snoops palette writes, ten bits
// - bit 6 enables normal parity action
// - wait cycle bit reads zero, no stepping
// - bit 8 gates system error driver
// - bit 9 enables fast back-to-back initiation
// - command bits 15:10 read zero
// - status bit 20 advertises capability list
// - status bit 21 reads one, 66MHz
// - status bit 23 reads one
// - bit 24 sets on master data parity
// - status bits 26:25 read 01
// - bit 27 sets on signaled target abort
// - bit 28 sets on received target abort
// - bit 29 sets on received master abort
// - bit 30 sets when error output asserted
// - bit 31 sets on any parity error
// - identity and revision fields hardwired
`default_nettype none
module bpc_cfg_header
  import bpc_pkg::*;
#(
  // arbitrary identity values, not any real part
  parameter logic [15:0] VENDOR_CODE = 16'hAB01,
  parameter logic [15:0] DEVICE_CODE = 16'hCD02,
  parameter logic [7:0] REVISION_CODE = 8'h01
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire bpc_events_t events,
  input wire logic serr_request,
  input wire bpc_decode_t decode_req,
  input wire logic mwi_forward,
  output bpc_enables_t enables,
  output logic decode_hit,
  output logic mwi_allowed,
  output logic primary_system_error_out,
  output logic primary_system_error_oe_n
);
  // ----------------------------------------
  // address phase capture
  // ----------------------------------------
  logic ph_valid;
  logic ph_write;
  logic [7:0] ph_addr;
  logic next_ph_valid;
  logic next_ph_write;
  logic [7:0] next_ph_addr;
  logic [15:0] command;
  logic [15:0] next_command;
  logic [BPC_NUM_FLAGS-1:0] flags;
  logic [BPC_NUM_FLAGS-1:0] flag_set;
  logic [BPC_NUM_FLAGS-1:0] flag_clr;
  logic [31:0] next_hrdata;
  logic serr_drive;
  logic wr_cmdstat;

  function automatic logic is_palette(input logic [15:0] a);
    is_palette = (a[9:0] == BPC_PAL_A) || (a[9:0] == BPC_PAL_B) ||
                 (a[9:0] == BPC_PAL_C);
  endfunction : is_palette

  always_comb begin
    next_ph_valid = 1'b0;
    next_ph_write = ph_write;
    next_ph_addr = ph_addr;
    if (hready && hsel &&
        (htrans == BPC_HTRANS_NONSEQ || htrans == BPC_HTRANS_SEQ)) begin
      next_ph_valid = 1'b1;
      next_ph_write = hwrite;
      next_ph_addr = haddr[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_valid <= 1'b0;
      ph_write <= 1'b0;
      ph_addr <= 8'h00;
    end else if (clk_en) begin
      ph_valid <= next_ph_valid;
      ph_write <= next_ph_write;
      ph_addr <= next_ph_addr;
    end
  end

  // zero wait state, always okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign wr_cmdstat = ph_valid && ph_write && ph_addr == BPC_OFF_CMDSTAT;

  // ----------------------------------------
  // command register
  // ----------------------------------------
  always_comb begin
    next_command = command;
    if (wr_cmdstat) begin
      next_command = hwdata[15:0] & BPC_CMD_WMASK;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      command <= 16'h0000;
    end else if (clk_en) begin
      command <= next_command;
    end
  end

  // ----------------------------------------
  // sticky status flags
  // ----------------------------------------
  // master data parity error
  assign flag_set[0] = events.dpe_master;
  assign flag_set[1] = events.sig_tabort;
  assign flag_set[2] = events.rcv_tabort;
  assign flag_set[3] = events.rcv_mabort;
  assign flag_set[4] = serr_drive;
  // any parity error, regardless of bit 6
  assign flag_set[5] = events.parity_any;

  assign flag_clr[0] = wr_cmdstat && hwdata[BPC_ST_DPE_MASTER];
  assign flag_clr[1] = wr_cmdstat && hwdata[BPC_ST_SIG_TABORT];
  assign flag_clr[2] = wr_cmdstat && hwdata[BPC_ST_RCV_TABORT];
  assign flag_clr[3] = wr_cmdstat && hwdata[BPC_ST_RCV_MABORT];
  assign flag_clr[4] = wr_cmdstat && hwdata[BPC_ST_SIG_SERR];
  assign flag_clr[5] = wr_cmdstat && hwdata[BPC_ST_PARITY];

  genvar gi;
  generate
    for (gi = 0; gi < BPC_NUM_FLAGS; gi++) begin : g_flag
      bpc_flag u_flag (
        .hclk(hclk),
        .hresetn(hresetn),
        .clk_en(clk_en),
        .set(flag_set[gi]),
        .clear(flag_clr[gi]),
        .flag(flags[gi])
      );
    end
  endgenerate

  // ----------------------------------------
  // read data
  // ----------------------------------------
  always_comb begin
    next_hrdata = 32'h0000_0000;
    if (next_ph_valid && !hwrite) begin
      case (haddr[7:0])
        BPC_OFF_IDENT: next_hrdata = {DEVICE_CODE, VENDOR_CODE};
        BPC_OFF_CMDSTAT: begin
          next_hrdata = {BPC_STATUS_FIXED, command};
          next_hrdata[BPC_ST_DPE_MASTER] = flags[0];
          next_hrdata[BPC_ST_SIG_TABORT] = flags[1];
          next_hrdata[BPC_ST_RCV_TABORT] = flags[2];
          next_hrdata[BPC_ST_RCV_MABORT] = flags[3];
          next_hrdata[BPC_ST_SIG_SERR] = flags[4];
          next_hrdata[BPC_ST_PARITY] = flags[5];
        end
        BPC_OFF_REV: next_hrdata = {24'h00_0000, REVISION_CODE};
        default: next_hrdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (clk_en) begin
      hrdata <= next_hrdata;
    end
  end

  // ----------------------------------------
  // datapath enables
  // ----------------------------------------
  // io response enable
  assign enables.io_respond = command[BPC_CMD_IO];
  assign enables.mem_respond = command[BPC_CMD_MEM];
  assign enables.master_enable = command[BPC_CMD_MASTER];
  assign enables.palette_snoop = command[BPC_CMD_PALETTE];
  assign enables.parity_respond = command[BPC_CMD_PARITY];
  assign enables.fast_b2b_enable = command[BPC_CMD_FB2B];

  // invalidate only when forwarding and mastering
  assign mwi_allowed = mwi_forward && command[BPC_CMD_MASTER];

  // decode result combines window enables and palette snoop
  always_comb begin
    decode_hit = 1'b0;
    if (decode_req.is_io && command[BPC_CMD_IO]) begin
      decode_hit = 1'b1;
    end
    if (decode_req.is_mem && command[BPC_CMD_MEM]) begin
      decode_hit = 1'b1;
    end
    if (decode_req.is_io && decode_req.is_write &&
        command[BPC_CMD_PALETTE] && is_palette(decode_req.addr)) begin
      decode_hit = 1'b1;
    end
  end

  // ----------------------------------------
  // system error driver
  // ----------------------------------------
  // driver only while enabled
  assign serr_drive = serr_request && command[BPC_CMD_SERR];
  // open drain: drive low, oe low while driving
  assign primary_system_error_out = 1'b0;
  assign primary_system_error_oe_n = !serr_drive;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_serr_gate: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !command[BPC_CMD_SERR] |-> primary_system_error_oe_n)
    else $error("error driver active while disabled");

  a_serr_flag: assert property (
    @(posedge hclk) disable iff (!hresetn)
    clk_en && !primary_system_error_oe_n |=> flags[4])
    else $error("signaled error flag not set");

  a_set_wins: assert property (
    @(posedge hclk) disable iff (!hresetn)
    clk_en && events.parity_any && flag_clr[5] |=> flags[5])
    else $error("clear beat a parity set");

  a_clear_one: assert property (
    @(posedge hclk) disable iff (!hresetn)
    clk_en && flag_clr[2] && !events.rcv_tabort |=> !flags[2])
    else $error("write one did not clear");

  a_cmd_ro_zero: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (command & ~BPC_CMD_WMASK) == 16'h0000)
    else $error("read-only command bit set");

  a_status_fixed: assert property (
    @(posedge hclk) disable iff (!hresetn)
    clk_en && next_ph_valid && !hwrite && haddr[7:0] == BPC_OFF_CMDSTAT
    |=> {hrdata[26:25], hrdata[23:16]} ==
        {BPC_STATUS_FIXED[10:9], BPC_STATUS_FIXED[7:0]})
    else $error("fixed status bits wrong");

  a_io_enable: assert property (
    @(posedge hclk) disable iff (!hresetn)
    decode_req.is_io && !decode_req.is_write && !command[BPC_CMD_IO]
    |-> !decode_hit)
    else $error("io decoded while disabled");

  a_mem_enable: assert property (
    @(posedge hclk) disable iff (!hresetn)
    decode_req.is_mem && !decode_req.is_io && !command[BPC_CMD_MEM]
    |-> !decode_hit)
    else $error("memory decoded while disabled");

  a_cmd_write: assert property (
    @(posedge hclk) disable iff (!hresetn)
    clk_en && wr_cmdstat
    |=> {16'h0000, command} == ($past(hwdata) & {16'h0000, BPC_CMD_WMASK}))
    else $error("command write not stored");

  a_palette_hit: assert property (
    @(posedge hclk) disable iff (!hresetn)
    decode_req.is_io && decode_req.is_write && command[BPC_CMD_PALETTE] &&
    is_palette(decode_req.addr) |-> decode_hit)
    else $error("palette write not decoded");

  a_decode_off: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !command[BPC_CMD_IO] && !command[BPC_CMD_MEM] &&
    !command[BPC_CMD_PALETTE] |-> !decode_hit)
    else $error("decode hit with all spaces off");

  a_mwi_gate: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !command[BPC_CMD_MASTER] |-> !mwi_allowed)
    else $error("invalidate allowed while not mastering");

  a_parity_set: assert property (
    @(posedge hclk) disable iff (!hresetn)
    clk_en && events.parity_any |=> flags[5])
    else $error("parity event not recorded");

  a_ident_read: assert property (
    @(posedge hclk) disable iff (!hresetn)
    clk_en && next_ph_valid && !hwrite && haddr[7:0] == BPC_OFF_IDENT
    |=> hrdata == {DEVICE_CODE, VENDOR_CODE})
    else $error("identity word wrong");

  // while clock enable is high, read data drops to zero outside its data phase, so no stale word lingers
  a_read_idle: assert property (
    @(posedge hclk) disable iff (!hresetn)
    clk_en && !(next_ph_valid && !hwrite) |=> hrdata == 32'h0000_0000)
    else $error("read data outside data phase");

  // a low clock enable holds the command register and every flag
  a_freeze_hold: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !clk_en |=> $stable(command) && $stable(flags))
    else $error("state moved while frozen");

  c_cmd_write: cover property (@(posedge hclk) disable iff (!hresetn)
    wr_cmdstat);
  c_serr: cover property (@(posedge hclk) disable iff (!hresetn)
    !primary_system_error_oe_n);
  c_palette: cover property (@(posedge hclk) disable iff (!hresetn)
    decode_hit && is_palette(decode_req.addr));
  c_set_wins: cover property (@(posedge hclk) disable iff (!hresetn)
    events.parity_any && flag_clr[5]);
  c_freeze: cover property (@(posedge hclk) disable iff (!hresetn)
    !clk_en && hsel);
endmodule : bpc_cfg_header
`default_nettype wire

// file: tb/bpc_core_model.sv
// bridge core stand-in: turns a bench request into a one-cycle event pulse
// assumes the same hclk and hresetn as the configuration header
`default_nettype none
module bpc_core_model
  import bpc_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ev_go,
  input wire logic [2:0] ev_idx,
  output bpc_events_t events
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // event pulse
  // ----------------------------------------
  // registered so a pulse never lands in the same step as the request
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      events <= '0;
    end else begin
      events <= ev_go ? bpc_events_t'(6'h01 << ev_idx) : '0;
    end
  end
endmodule : bpc_core_model
`default_nettype wire

// file: tb/testbench.sv
// self-checking bench for the primary configuration header
// assumes the header answers with zero wait states, as handed over
`default_nettype none
module testbench
  import bpc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic serr_request = 1'b0;
  bpc_decode_t decode_req = '0;
  logic mwi_forward = 1'b0;
  bpc_enables_t enables;
  logic decode_hit;
  logic mwi_allowed;
  logic se_out;
  logic se_oe_n;
  logic clk_en = 1'b1;
  logic ev_go = 1'b0;
  logic [2:0] ev_idx = 3'h0;
  bpc_events_t events;
  int failures = 0;
  int checks = 0;
  logic [31:0] st;
  int pos [6] = '{24, 27, 28, 29, 30, 31};

  always #2 hclk = ~hclk;

  bpc_core_model core_u (.hclk(hclk), .hresetn(hresetn), .ev_go(ev_go),
    .ev_idx(ev_idx), .events(events));

  bpc_cfg_header dut_u (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .events(events),
    .serr_request(serr_request), .decode_req(decode_req),
    .mwi_forward(mwi_forward), .enables(enables), .decode_hit(decode_hit),
    .mwi_allowed(mwi_allowed), .primary_system_error_out(se_out),
    .primary_system_error_oe_n(se_oe_n));

  // ----------------------------------------
  // checking and closing
  // ----------------------------------------
  task automatic results();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : results

  task automatic chk(input string name, input logic [31:0] seen,
                     input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // ----------------------------------------
  // ahb-lite single word transfer
  // ----------------------------------------
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    rd = 32'h0;
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= BPC_HTRANS_NONSEQ;
    hwrite <= wr;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    // read data is taken at the edge that ends the data phase
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 100);
    rd = hrdata;
    if (n >= 100) begin
      failures++;
      results();
    end
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask : wr

  task automatic rd_chk(input string name, input logic [7:0] a,
                        input logic [31:0] exp);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    chk(name, x, exp);
  endtask : rd_chk

  task automatic dchk(input logic io, input logic mem, input logic w,
                      input logic [15:0] a, input logic exp);
    decode_req <= '{is_io: io, is_mem: mem, is_write: w, addr: a};
    @(negedge hclk);
    chk("decode_hit", {31'h0, decode_hit}, {31'h0, exp});
    @(posedge hclk);
  endtask : dchk

  task automatic pulse(input int i);
    ev_go <= 1'b1;
    ev_idx <= 3'(i);
    @(posedge hclk);
    ev_go <= 1'b0;
    repeat (2) @(posedge hclk);
  endtask : pulse

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd_chk("ident", BPC_OFF_IDENT, 32'hCD02_AB01);
    wr(BPC_OFF_IDENT, 32'hFFFF_FFFF);
    rd_chk("ident_ro", BPC_OFF_IDENT, 32'hCD02_AB01);
    rd_chk("revision", BPC_OFF_REV, 32'h0000_0001);
    rd_chk("cmdstat_rst", BPC_OFF_CMDSTAT, 32'h02B0_0000);
    chk("oe_n_rst", {31'h0, se_oe_n}, 32'h1);
    rd_chk("unmapped", BPC_OFF_EVENT, 32'h0);
    // only writable command bits stick; read-only ones stay zero
    wr(BPC_OFF_CMDSTAT, 32'h00FF_FFFF);
    rd_chk("cmd_all", BPC_OFF_CMDSTAT, 32'h02B0_0367);
    chk("enables_all", {26'h0, enables}, 32'h3F);
    mwi_forward <= 1'b1;
    @(negedge hclk);
    chk("mwi_on", {31'h0, mwi_allowed}, 32'h1);
    @(posedge hclk);
    // io decode gated by bit 0
    wr(BPC_OFF_CMDSTAT, 32'h0000_0001);
    dchk(1'b1, 1'b0, 1'b0, 16'h1234, 1'b1);
    dchk(1'b0, 1'b1, 1'b0, 16'h1234, 1'b0);
    chk("mwi_off", {31'h0, mwi_allowed}, 32'h0);
    // memory decode gated by bit 1
    wr(BPC_OFF_CMDSTAT, 32'h0000_0002);
    dchk(1'b0, 1'b1, 1'b0, 16'h1234, 1'b1);
    dchk(1'b1, 1'b0, 1'b1, 16'h1234, 1'b0);
    // palette writes with any alias bits, reads and neighbours miss
    wr(BPC_OFF_CMDSTAT, 32'h0000_0020);
    dchk(1'b1, 1'b0, 1'b1, 16'hFFC6, 1'b1);
    dchk(1'b1, 1'b0, 1'b1, 16'h07C8, 1'b1);
    dchk(1'b1, 1'b0, 1'b1, 16'h03C9, 1'b1);
    dchk(1'b1, 1'b0, 1'b0, 16'h03C9, 1'b0);
    dchk(1'b1, 1'b0, 1'b1, 16'h03C7, 1'b0);
    chk("enables_pal", {26'h0, enables}, 32'h04);
    wr(BPC_OFF_CMDSTAT, 32'h0000_0000);
    dchk(1'b1, 1'b0, 1'b1, 16'h03C6, 1'b0);
    chk("enables_off", {26'h0, enables}, 32'h00);
    // sticky flags gather, then clear one at a time
    st = 32'h02B0_0000;
    for (int i = 0; i < 6; i++) begin
      if (i != 4) begin
        pulse(i);
        st = st | (32'h1 << pos[i]);
        rd_chk("flag_set", BPC_OFF_CMDSTAT, st);
      end
    end
    for (int i = 0; i < 6; i++) begin
      if (i != 4) begin
        wr(BPC_OFF_CMDSTAT, 32'h1 << pos[i]);
        st = st & ~(32'h1 << pos[i]);
        rd_chk("flag_clr", BPC_OFF_CMDSTAT, st);
      end
    end
    // a clear meeting a new parity event loses to it
    ev_go <= 1'b1;
    ev_idx <= 3'h5;
    fork
      wr(BPC_OFF_CMDSTAT, 32'h8000_0000);
      begin
        @(posedge hclk);
        ev_go <= 1'b0;
      end
    join
    rd_chk("set_wins", BPC_OFF_CMDSTAT, 32'h82B0_0000);
    wr(BPC_OFF_CMDSTAT, 32'h8000_0000);
    rd_chk("set_gone", BPC_OFF_CMDSTAT, 32'h02B0_0000);
    // system error driven only while enabled, and recorded
    wr(BPC_OFF_CMDSTAT, 32'h0000_0100);
    serr_request <= 1'b1;
    @(negedge hclk);
    chk("oe_n_on", {30'h0, se_out, se_oe_n}, 32'h0);
    @(posedge hclk);
    serr_request <= 1'b0;
    rd_chk("serr_flag", BPC_OFF_CMDSTAT, 32'h42B0_0100);
    wr(BPC_OFF_CMDSTAT, 32'h4000_0000);
    serr_request <= 1'b1;
    @(negedge hclk);
    chk("oe_n_gated", {31'h0, se_oe_n}, 32'h1);
    @(posedge hclk);
    rd_chk("serr_quiet", BPC_OFF_CMDSTAT, 32'h02B0_0000);
    serr_request <= 1'b0;
    // clock enable low: writes and events leave every register alone
    wr(BPC_OFF_CMDSTAT, 32'h0000_0367);
    clk_en <= 1'b0;
    pulse(0);
    wr(BPC_OFF_CMDSTAT, 32'h0000_0000);
    clk_en <= 1'b1;
    chk("enables_frz", {26'h0, enables}, 32'h3F);
    rd_chk("frozen", BPC_OFF_CMDSTAT, 32'h02B0_0367);
    // a reset in mid-run clears command and flags again
    pulse(5);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    chk("oe_n_rst2", {31'h0, se_oe_n}, 32'h1);
    chk("hrdata_rst", hrdata, 32'h0);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd_chk("cmdstat_rst2", BPC_OFF_CMDSTAT, 32'h02B0_0000);
    chk("enables_rst", {26'h0, enables}, 32'h00);
    chk("hresp", {31'h0, hresp}, 32'h0);
    results();
  end
endmodule : testbench
`default_nettype wire
